/* tcp_top.sv */
// timer unit top: ahb-lite registers, main counter, modulus and channel array
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`include "tcp_regs.svh"
`default_nettype none
module tcp_top
   import tcp_pkg::*;
#(
   parameter int NCH = 2
)
(
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            rstn,
   // ahb-lite slave
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic                 hreadyout,
   output logic                 hresp,
   output logic [31:0]          hrdata,
   // channel pins
   input  wire logic [NCH-1:0]  chanPinIn,
   output logic      [NCH-1:0]  chanPinOut,
   output logic      [NCH-1:0]  chanPinOe,
   // interrupt requests
   output logic                 ovfIrq,
   output logic      [NCH-1:0]  chanIrq
);
   tcp_cnt_if  cntBus ();

   tcp_bus_t   busState;
   logic [7:0] addrQ;
   logic       writeQ;
   logic       dataPh;
   logic       wrStb;
   logic       rdStb;
   logic [7:0] wbyte;
   logic [7:0] chOff;
   logic [3:0] chIdx;
   logic [3:0] chSub;
   logic       chHit;
   logic [7:0] rbyte;

   logic       ovfFlag;
   logic       ovfArm;
   logic       ovfIrqEnable;
   logic       centerSel;
   logic       run;
   tcp_count_t count;
   logic       countUp;
   tcp_count_t modulus;
   logic [7:0] modBufH;
   logic [7:0] modBufL;
   logic       modGotH;
   logic       modGotL;
   tcp_count_t next_count;
   logic       next_up;
   logic       cntEvent;
   tcp_count_t term;

   logic [NCH-1:0] wrCsc;
   logic [NCH-1:0] wrValH;
   logic [NCH-1:0] wrValL;
   logic [NCH-1:0] rdCsc;
   logic [7:0]     chStatus [NCH];
   tcp_count_t     chValue  [NCH];

   // bus: one wait state so that read data leaves a flip-flop
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         busState  <= TCP_BUS_IDLE;
         addrQ     <= `TCP_RST_BYTE;
         writeQ    <= 1'b0;
         hreadyout <= 1'b1;
      end
      else if (busState == TCP_BUS_IDLE)
      begin
         if (hsel && hready && htrans[1])
         begin
            busState  <= TCP_BUS_DATA;
            addrQ     <= haddr[7:0];
            writeQ    <= hwrite;
            hreadyout <= 1'b0;
         end
      end
      else
      begin
         busState  <= TCP_BUS_IDLE;
         hreadyout <= 1'b1;
      end
   end

   // response is always okay
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         hresp <= 1'b0;
      else
         hresp <= 1'b0;
   end

   // decode of the data phase
   assign dataPh = (busState == TCP_BUS_DATA);
   assign wrStb  = dataPh && writeQ;
   assign rdStb  = dataPh && !writeQ;
   assign wbyte  = hwdata[7:0];
   assign chOff  = addrQ - `TCP_OFF_CH0;
   assign chIdx  = chOff[7:4];
   assign chSub  = chOff[3:0];
   assign chHit  = (addrQ >= `TCP_OFF_CH0) && (int'(chIdx) < NCH);

   // read byte mux; unmapped addresses read zero
   always_comb
   begin
      rbyte = `TCP_RST_BYTE;
      case (addrQ)
         `TCP_OFF_TSC:  rbyte = {ovfFlag, ovfIrqEnable, centerSel, 4'h0, run};
         `TCP_OFF_CNTH: rbyte = count[15:8];
         `TCP_OFF_CNTL: rbyte = count[7:0];
         `TCP_OFF_MODH: rbyte = modulus[15:8];
         `TCP_OFF_MODL: rbyte = modulus[7:0];
         default:
         begin
            for (int i = 0; i < NCH; i++)
            begin
               if (chHit && (int'(chIdx) == i))
               begin
                  if (chSub == `TCP_SUB_CSC)
                     rbyte = chStatus[i];
                  else if (chSub == `TCP_SUB_VALH)
                     rbyte = chValue[i][15:8];
                  else if (chSub == `TCP_SUB_VALL)
                     rbyte = chValue[i][7:0];
               end
            end
         end
      endcase
   end

   // read data register
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         hrdata <= {`TCP_PAD_DATA, `TCP_RST_BYTE};
      else if (rdStb)
         hrdata <= {`TCP_PAD_DATA, rbyte};
   end

   // timer control bits
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ovfIrqEnable <= 1'b0;
         centerSel    <= 1'b0;
         run          <= 1'b0;
      end
      else if (wrStb && (addrQ == `TCP_OFF_TSC))
      begin
         ovfIrqEnable <= wbyte[`TCP_BIT_IE];
         centerSel    <= wbyte[`TCP_BIT_CENTER];
         run          <= wbyte[`TCP_BIT_RUN];
      end
   end

   // next counter value: up only, or up/down with reversal at the modulus
   always_comb
   begin
      next_count = count;
      next_up    = countUp;
      cntEvent   = 1'b0;
      term       = (modulus == `TCP_RST_WORD) ? `TCP_ALL_ONES : modulus;
      if (run)
      begin
         if (!centerSel)
         begin
            next_up = 1'b1;
            if (count >= term)
            begin
               next_count = `TCP_RST_WORD;
               cntEvent   = 1'b1;
            end
            else
               next_count = count + `TCP_ONE;
         end
         else if (countUp)
         begin
            // modulus zero cannot reverse properly; software avoids it
            if (count >= term)
            begin
               next_count = count - `TCP_ONE;
               next_up    = 1'b0;
               cntEvent   = 1'b1;
            end
            else
               next_count = count + `TCP_ONE;
         end
         else if (count == `TCP_RST_WORD)
         begin
            next_count = count + `TCP_ONE;
            next_up    = 1'b1;
         end
         else
            next_count = count - `TCP_ONE;
      end
   end

   // main counter; any write to either count byte restarts it
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count   <= `TCP_RST_WORD;
         countUp <= 1'b1;
      end
      else if (wrStb && ((addrQ == `TCP_OFF_CNTH) || (addrQ == `TCP_OFF_CNTL)))
      begin
         count   <= `TCP_RST_WORD;
         countUp <= 1'b1;
      end
      else
      begin
         count   <= next_count;
         countUp <= next_up;
      end
   end

   // buffered modulus; timer control write drops a half-written value
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         modulus <= `TCP_RST_WORD;
         modBufH <= `TCP_RST_BYTE;
         modBufL <= `TCP_RST_BYTE;
         modGotH <= 1'b0;
         modGotL <= 1'b0;
      end
      else if (wrStb && (addrQ == `TCP_OFF_TSC))
      begin
         modGotH <= 1'b0;
         modGotL <= 1'b0;
      end
      else if (modGotH && modGotL && (cntEvent || !run))
      begin
         // loads on the same edge as the channels, a stopped timer at once
         modulus <= {modBufH, modBufL};
         modGotH <= 1'b0;
         modGotL <= 1'b0;
      end
      else if (wrStb && (addrQ == `TCP_OFF_MODH))
      begin
         modBufH <= wbyte;
         modGotH <= 1'b1;
      end
      else if (wrStb && (addrQ == `TCP_OFF_MODL))
      begin
         modBufL <= wbyte;
         modGotL <= 1'b1;
      end
   end

   // overflow flag: set wins, an event disarms the two-step clear
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ovfFlag <= 1'b0;
         ovfArm  <= 1'b0;
      end
      else if (cntEvent)
      begin
         ovfFlag <= 1'b1;
         ovfArm  <= 1'b0;
      end
      else if (wrStb && (addrQ == `TCP_OFF_TSC) && !wbyte[`TCP_BIT_FLAG] && ovfArm)
      begin
         ovfFlag <= 1'b0;
         ovfArm  <= 1'b0;
      end
      else if (rdStb && (addrQ == `TCP_OFF_TSC) && ovfFlag)
         ovfArm <= 1'b1;
   end

   // overflow request as a level
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         ovfIrq <= 1'b0;
      else
         ovfIrq <= (ovfFlag || cntEvent) && ovfIrqEnable;
   end

   // counter bundle to the channels
   assign cntBus.count     = count;
   assign cntBus.nextCount = next_count;
   assign cntBus.modulus   = modulus;
   assign cntBus.tick      = run;
   assign cntBus.stepUp    = next_up;
   assign cntBus.overflow  = cntEvent;
   assign cntBus.atZero    = run && (next_count == `TCP_RST_WORD);
   assign cntBus.center    = centerSel;

   // channel array
   for (genvar g = 0; g < NCH; g++)
   begin : gen_chan
      assign wrCsc[g]  = wrStb && chHit && (int'(chIdx) == g) && (chSub == `TCP_SUB_CSC);
      assign wrValH[g] = wrStb && chHit && (int'(chIdx) == g) && (chSub == `TCP_SUB_VALH);
      assign wrValL[g] = wrStb && chHit && (int'(chIdx) == g) && (chSub == `TCP_SUB_VALL);
      assign rdCsc[g]  = rdStb && chHit && (int'(chIdx) == g) && (chSub == `TCP_SUB_CSC);
      tcp_channel u_chan
      (
         .core_clk (core_clk),
         .rstn     (rstn),
         .cnt      (cntBus.sink),
         .wrCsc    (wrCsc[g]),
         .wrValH   (wrValH[g]),
         .wrValL   (wrValL[g]),
         .rdCsc    (rdCsc[g]),
         .wdata    (wbyte),
         .status   (chStatus[g]),
         .value    (chValue[g]),
         .pinIn    (chanPinIn[g]),
         .pinOut   (chanPinOut[g]),
         .pinOe    (chanPinOe[g]),
         .irq      (chanIrq[g])
      );
   end
endmodule
`default_nettype wire

/* tcp_regs.svh */
// register offsets, field positions, reset values and constants of the timer unit
// Operation
// - compare match sets, clears or toggles pin
// - compare value loads after both bytes written
// - compare match sets channel flag, irq enable
// - edge pwm counts up, modulus period, value duty
// - polarity bit inverts overflow and match actions
// - zero gives 0%, above modulus gives 100%
// - edge pwm value loads at counter zero
// - center pwm doubles width and period
// - zero or negative 0%, above modulus 100%
// - center match up drives low, down high
// - center pwm buffers load at counter reversal at the modulus
// - all pwm reloads take effect together while running; a stopped timer loads only the modulus
// - control writes discard pending buffered bytes
// - flags set on capture edge or match
// - level irq while flag and enable set
// - flag clears by read-set then write zero
// - new event restarts the clearing sequence
// - center select makes all channels center pwm
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH
// byte addresses of the timer registers
`define TCP_OFF_TSC    8'h00
`define TCP_OFF_CNTH   8'h04
`define TCP_OFF_CNTL   8'h08
`define TCP_OFF_MODH   8'h0c
`define TCP_OFF_MODL   8'h10
`define TCP_OFF_CH0    8'h20
// offsets inside one channel block of sixteen bytes
`define TCP_SUB_CSC    4'h0
`define TCP_SUB_VALH   4'h4
`define TCP_SUB_VALL   4'h8
// status/control field positions
`define TCP_BIT_FLAG   7
`define TCP_BIT_IE     6
`define TCP_BIT_CENTER 5
`define TCP_BIT_RUN    0
`define TCP_BIT_MSB    5
`define TCP_BIT_MSA    4
`define TCP_BIT_ELSB   3
`define TCP_BIT_ELSA   2
`define TCP_BIT_SIGN   15
// reset values and count constants
`define TCP_RST_BYTE   8'h00
`define TCP_RST_WORD   16'h0000
`define TCP_ALL_ONES   16'hffff
`define TCP_ONE        16'h0001
`define TCP_PAD_DATA   24'h000000
`endif

/* tcp_pkg.sv */
// types shared by the timer unit modules
`default_nettype none
package tcp_pkg;
   typedef logic [15:0] tcp_count_t;
   typedef enum logic [1:0] {TCP_BUS_IDLE = 2'b00, TCP_BUS_DATA = 2'b01} tcp_bus_t;
   typedef enum logic [1:0]
   {
      TCP_MODE_CAPTURE = 2'b00,
      TCP_MODE_COMPARE = 2'b01,
      TCP_MODE_EDGE    = 2'b11,
      TCP_MODE_CENTER  = 2'b10
   } tcp_mode_t;
endpackage
`default_nettype wire

/* tcp_cnt_if.sv */
// counter bundle passed from the timer core to each channel
`default_nettype none
interface tcp_cnt_if;
   import tcp_pkg::*;
   tcp_count_t count;      // present counter value
   tcp_count_t nextCount;  // value reached at this edge
   tcp_count_t modulus;    // active modulus
   logic       tick;       // counter steps at this edge
   logic       stepUp;     // this step counts upward
   logic       overflow;   // end of period at this edge
   logic       atZero;     // counter reaches zero at this edge
   logic       center;     // up/down counting selected
   modport source (output count, nextCount, modulus, tick, stepUp, overflow, atZero, center);
   modport sink   (input  count, nextCount, modulus, tick, stepUp, overflow, atZero, center);
endinterface
`default_nettype wire

/* tcp_channel.sv */
// one timer channel: capture, compare, edge and center pwm
`include "tcp_regs.svh"
`default_nettype none
module tcp_channel
   import tcp_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // counter bundle
   tcp_cnt_if.sink         cnt,
   // register strobes
   input  wire logic       wrCsc,
   input  wire logic       wrValH,
   input  wire logic       wrValL,
   input  wire logic       rdCsc,
   input  wire logic [7:0] wdata,
   // read back
   output logic      [7:0] status,
   output tcp_count_t      value,
   // pin and interrupt
   input  wire logic       pinIn,
   output logic            pinOut,
   output logic            pinOe,
   output logic            irq
);
   logic       flag;
   logic       clearArm;
   logic       irqEnable;
   logic [1:0] modeSel;
   logic [1:0] edgeSel;
   logic [7:0] bufH;
   logic [7:0] bufL;
   logic       gotH;
   logic       gotL;
   logic       sync1;
   logic       sync2;
   logic       sync3;
   logic       level;
   tcp_mode_t  mode;
   logic       match;
   logic       capEvent;
   logic       chanEvent;
   logic       reload;
   logic       elsA;

   // center select overrides every channel's own mode
   always_comb
   begin
      if (cnt.center)
         mode = TCP_MODE_CENTER;
      else if (modeSel == 2'b00)
         mode = TCP_MODE_CAPTURE;
      else if (modeSel == 2'b01)
         mode = TCP_MODE_COMPARE;
      else
         mode = TCP_MODE_EDGE;
   end

   // match is judged on the value the counter takes at this edge
   assign match    = cnt.tick && (cnt.nextCount == value);
   assign elsA     = edgeSel[0];
   assign capEvent = (sync2 == sync3) && (sync3 != level)
                     && (sync3 ? edgeSel[0] : edgeSel[1]);
   assign chanEvent = (mode == TCP_MODE_CAPTURE) ? capEvent : match;
   // compare loads at once, edge pwm at zero, center pwm at reversal
   assign reload   = gotH && gotL && ((mode == TCP_MODE_COMPARE) || (mode == TCP_MODE_CAPTURE)
                     || ((mode == TCP_MODE_EDGE) && cnt.atZero)
                     || ((mode == TCP_MODE_CENTER) && cnt.overflow));
   assign status   = {flag, irqEnable, modeSel, edgeSel, 2'b00};

   // pin synchroniser; only the second stage reads the first
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         sync1 <= pinIn;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3)
            level <= sync3;
      end
   end

   // control bits
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqEnable <= 1'b0;
         modeSel   <= 2'b00;
         edgeSel   <= 2'b00;
      end
      else if (wrCsc)
      begin
         irqEnable <= wdata[`TCP_BIT_IE];
         modeSel   <= {wdata[`TCP_BIT_MSB], wdata[`TCP_BIT_MSA]};
         edgeSel   <= {wdata[`TCP_BIT_ELSB], wdata[`TCP_BIT_ELSA]};
      end
   end

   // byte pairing; a control write drops a half-written value
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bufH <= `TCP_RST_BYTE;
         bufL <= `TCP_RST_BYTE;
         gotH <= 1'b0;
         gotL <= 1'b0;
      end
      else if (wrCsc || reload)
      begin
         gotH <= 1'b0;
         gotL <= 1'b0;
      end
      else
      begin
         if (wrValH)
         begin
            bufH <= wdata;
            gotH <= 1'b1;
         end
         if (wrValL)
         begin
            bufL <= wdata;
            gotL <= 1'b1;
         end
      end
   end

   // active value; capture wins over a pending reload
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         value <= `TCP_RST_WORD;
      else if ((mode == TCP_MODE_CAPTURE) && capEvent)
         value <= cnt.count;
      else if (reload)
         value <= {bufH, bufL};
   end

   // flag: set wins over clear, an event cancels the armed read
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         flag     <= 1'b0;
         clearArm <= 1'b0;
      end
      else if (chanEvent)
      begin
         flag     <= 1'b1;
         clearArm <= 1'b0;
      end
      else if (wrCsc && !wdata[`TCP_BIT_FLAG] && clearArm)
      begin
         flag     <= 1'b0;
         clearArm <= 1'b0;
      end
      else if (rdCsc && flag)
         clearArm <= 1'b1;
   end

   // level request follows flag and enable
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= (flag || chanEvent) && irqEnable;
   end

   // pin actions per mode
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pinOut <= 1'b0;
         pinOe  <= 1'b0;
      end
      else
      begin
         pinOe <= (mode != TCP_MODE_CAPTURE) && (edgeSel != 2'b00);
         case (mode)
            TCP_MODE_COMPARE:
            begin
               if (match)
               begin
                  case (edgeSel)
                     2'b01:   pinOut <= ~pinOut;
                     2'b10:   pinOut <= 1'b0;
                     2'b11:   pinOut <= 1'b1;
                     default: pinOut <= pinOut;
                  endcase
               end
            end
            TCP_MODE_EDGE:
            begin
               if (value == `TCP_RST_WORD)
                  pinOut <= elsA;
               else if (match)
                  pinOut <= elsA;
               else if (cnt.overflow)
                  pinOut <= ~elsA;
            end
            TCP_MODE_CENTER:
            begin
               // each half period contributes value counts of width
               if ((value == `TCP_RST_WORD) || value[`TCP_BIT_SIGN])
                  pinOut <= elsA;
               else if (value > cnt.modulus)
                  pinOut <= ~elsA;
               else if (match)
                  pinOut <= cnt.stepUp ? elsA : ~elsA;
            end
            default:
               pinOut <= pinOut;
         endcase
      end
   end
endmodule
`default_nettype wire

/* tcp_load_model.sv */
// pin load model: tallies the driven-high time of one channel pin
`default_nettype none
module tcp_load_model
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // channel pin
   input  wire logic       pinOut,
   input  wire logic       pinOe,
   // statistics
   input  wire logic       clearStat,
   output logic      [7:0] highCnt,
   output logic      [7:0] cycleCnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pinLevel;
   // an undriven pin is pulled low by the load, never left at its last level
   assign pinLevel = pinOe & pinOut;
   // high time over a window; the window length must be a whole number of periods
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         highCnt  <= 8'h00;
         cycleCnt <= 8'h00;
      end
      else if (clearStat)
      begin
         highCnt  <= 8'h00;
         cycleCnt <= 8'h00;
      end
      else
      begin
         highCnt  <= highCnt + {7'h00, pinLevel};
         cycleCnt <= cycleCnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* tcp_top_sva.sv */
// concurrent checks on the timer unit's bus, pin and interrupt ports
`default_nettype none
module tcp_top_sva
#(
   parameter int NCH = 2
)
(
   // clock and reset
   input  wire logic           core_clk,
   input  wire logic           rstn,
   // ahb-lite
   input  wire logic           hsel,
   input  wire logic [31:0]    haddr,
   input  wire logic [1:0]     htrans,
   input  wire logic           hwrite,
   input  wire logic [2:0]     hsize,
   input  wire logic [31:0]    hwdata,
   input  wire logic           hready,
   input  wire logic           hreadyout,
   input  wire logic           hresp,
   input  wire logic [31:0]    hrdata,
   // pins and interrupts
   input  wire logic [NCH-1:0] chanPinIn,
   input  wire logic [NCH-1:0] chanPinOut,
   input  wire logic [NCH-1:0] chanPinOe,
   input  wire logic           ovfIrq,
   input  wire logic [NCH-1:0] chanIrq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // transfer accepted while idle, then exactly one wait state
   sequence sTaken;
      hsel && hready && htrans[1] && hreadyout;
   endsequence
   sequence sOneWait;
      !hreadyout ##1 hreadyout;
   endsequence
   // a control write lands one or two edges before its effect shows
   sequence sRecentWrite;
      !$past(hreadyout) || !$past(hreadyout, 2);
   endsequence
   a_one_wait: assert property (sTaken |=> sOneWait)
      else $error("bus wait state not one cycle");
   a_wait_cause: assert property ($fell(hreadyout) |-> $past(hsel && hready && htrans[1]))
      else $error("wait state without a transfer");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_rdata_pad: assert property (hrdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
      else $error("read data moved outside a transfer");
   a_ovf_irq_hold: assert property ($fell(ovfIrq) |-> sRecentWrite)
      else $error("overflow irq dropped without a write");
   a_chan_irq_hold: assert property ($fell(chanIrq[0]) |-> sRecentWrite)
      else $error("channel irq dropped without a write");
   a_oe_by_write: assert property ($changed(chanPinOe) |-> sRecentWrite)
      else $error("pin enable moved without a write");
endmodule
bind tcp_top tcp_top_sva #(.NCH(NCH)) i_tcp_top_sva (.*);
`default_nettype wire

/* tcp_top_tb_top.sv */
// self-checking bench of the timer unit: bus tasks and pwm scenarios
`default_nettype none
module tcp_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, rstn, hsel, hwrite, hreadyout, hresp, ovfIrq, clearStat, pinSeen;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, chanPinIn, chanPinOut, chanPinOe, chanIrq;
   logic [2:0]  hsize;
   logic [7:0]  highCnt, cycleCnt;
   int          fail_count = 0;
   int          check_count = 0;
   tcp_top #(.NCH(2)) i_tcp_top (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chanPinIn(chanPinIn),
      .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .ovfIrq(ovfIrq), .chanIrq(chanIrq));
   tcp_load_model i_tcp_load_model (.core_clk(core_clk), .rstn(rstn), .pinOut(chanPinOut[0]),
      .pinOe(chanPinOe[0]), .clearStat(clearStat), .highCnt(highCnt), .cycleCnt(cycleCnt));
   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one single transfer; entered just after an edge, waits on hready under a bound
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] r);
      int n;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'b10;
      for (int ph = 0; ph < 2; ph++)
      begin
         n = 0;
         do
         begin
            @(posedge core_clk);
            n++;
         end
         while (hreadyout !== 1'b1 && n < 50);
         if (n >= 50)
         begin
            fail_count++;
            give_verdict();
         end
         // data phase starts once; a following call may raise htrans at this edge
         if (ph == 0)
         begin
            htrans <= 2'b00;
            hwdata <= {24'h000000, d};
         end
      end
      r = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      xfer(a, 1'b0, 8'h00, r);
      chk("register read", {8'h00, exp}, {8'h00, r});
   endtask
   // settle, then high cycles of channel 0 over a 40-cycle window
   task automatic duty(input logic [7:0] exp);
      tick(16);
      clearStat <= 1'b1;
      tick(1);
      clearStat <= 1'b0;
      tick(40);
      #1;
      chk("high time", {8'h00, exp}, {8'h00, highCnt});
      chk("window length", 16'h0028, {8'h00, cycleCnt});
   endtask
   initial
   begin
      core_clk = 1'b0; rstn = 1'b0; hsel = 1'b1; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'b010; hwdata = '0; chanPinIn = 2'b00; clearStat = 1'b0;
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      // reset values and an unmapped place
      rd(8'h00, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'hfc, 8'h5a);
      rd(8'hfc, 8'h00);
      // edge pwm mod 3 val 1, compare on channel 1 at 1
      wr(8'h0c, 8'h00);
      wr(8'h10, 8'h03);
      wr(8'h20, 8'h28);
      wr(8'h24, 8'h00);
      wr(8'h28, 8'h01);
      wr(8'h30, 8'h14);
      wr(8'h34, 8'h00);
      wr(8'h38, 8'h01);
      wr(8'h00, 8'h01);
      duty(8'd10);
      chk("pin enable", 16'h0001, {15'h0, chanPinOe[0]});
      // one match per four-count period, so the toggling pin inverts
      pinSeen = chanPinOut[1];
      tick(4);
      #1;
      chk("compare toggle", {15'h0, ~pinSeen}, {15'h0, chanPinOut[1]});
      rd(8'h30, 8'h94);
      wr(8'h20, 8'h24);
      duty(8'd30);
      // half pair discarded by control write, then completed in reverse order
      wr(8'h24, 8'h00);
      wr(8'h20, 8'h28);
      wr(8'h28, 8'h03);
      duty(8'd10);
      wr(8'h24, 8'h00);
      duty(8'd30);
      wr(8'h28, 8'h00);
      wr(8'h24, 8'h00);
      duty(8'd0);
      wr(8'h28, 8'h04);
      wr(8'h24, 8'h00);
      duty(8'd40);
      // channel flag, irq and the two-step clear
      wr(8'h20, 8'h68);
      duty(8'd40);
      chk("channel irq", 16'h0001, {15'h0, chanIrq[0]});
      wr(8'h00, 8'h00);
      wr(8'h20, 8'h68);
      rd(8'h20, 8'he8);
      wr(8'h20, 8'h68);
      rd(8'h20, 8'h68);
      chk("channel irq", 16'h0000, {15'h0, chanIrq[0]});
      // rising edge on a stopped counter at zero captures zero over the old value
      wr(8'h30, 8'h04);
      wr(8'h04, 8'h00);
      chanPinIn <= 2'b10;
      tick(6);
      rd(8'h38, 8'h00);
      // overflow flag and its irq
      wr(8'h00, 8'h41);
      tick(8);
      chk("overflow irq", 16'h0001, {15'h0, ovfIrq});
      wr(8'h00, 8'h40);
      rd(8'h00, 8'hc0);
      wr(8'h00, 8'h40);
      rd(8'h00, 8'h40);
      chk("overflow irq", 16'h0000, {15'h0, ovfIrq});
      // center pwm, modulus kept in its legal range
      wr(8'h10, 8'h04);
      wr(8'h0c, 8'h00);
      wr(8'h20, 8'h08);
      wr(8'h24, 8'h00);
      wr(8'h28, 8'h01);
      wr(8'h00, 8'h21);
      duty(8'd10);
      wr(8'h10, 8'h02);
      wr(8'h0c, 8'h00);
      duty(8'd20);
      wr(8'h28, 8'h00);
      wr(8'h24, 8'h00);
      duty(8'd0);
      wr(8'h24, 8'h80);
      wr(8'h28, 8'h05);
      duty(8'd0);
      wr(8'h24, 8'h00);
      wr(8'h28, 8'h05);
      duty(8'd40);
      give_verdict();
   end
endmodule
`default_nettype wire
